//--- design/nvac_pkg.sv
// shared constants and types of the nonvolatile access controller
package nvac_pkg;
   // register byte offsets on the bus
   localparam int         AXI_AW      = 8;
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_KEY     = 8'h04;
   localparam logic [7:0] OFS_ADDR    = 8'h08;
   localparam logic [7:0] OFS_DATA    = 8'h0c;
   localparam logic [7:0] OFS_TBLP    = 8'h10;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h1c;
   localparam logic [7:0] OFS_STAT    = 8'h20;
   // control register fields
   localparam int         B_RD        = 0;
   localparam int         B_WR        = 1;
   localparam int         B_WRITE_ENABLE_BIT      = 2;
   localparam int         B_WERR      = 3;
   localparam int         B_FREE      = 4;
   localparam int         B_CONFIG_SPACE_SELECT      = 6;
   localparam int         B_PGD       = 7;
   localparam logic [7:0] KEY_FIRST   = 8'h55;
   localparam logic [7:0] KEY_SECOND  = 8'haa;
   // interrupt and status fields
   localparam int         IRQ_W       = 3;
   localparam int         IRQ_WDONE   = 0;
   localparam int         IRQ_WERR    = 1;
   localparam int         IRQ_RDONE   = 2;
   localparam int         ST_BUSY     = 0;
   localparam int         ST_PWRT     = 1;
   localparam int         ST_ARMED    = 2;
   localparam int         ST_CP       = 3;
   localparam int         TP_W_DEF    = 22;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // timing, in ns and in 125 MHz cycles (rounded up)
   localparam longint CLK_MHZ        = 125;
   localparam longint WRITE_TIME_NS  = 4000000;
   localparam longint PWRT_TIME_NS   = 65600000;
   localparam int unsigned WRITE_CYCLES =
      32'((WRITE_TIME_NS * CLK_MHZ + 999) / 1000);
   localparam int unsigned PWRT_CYCLES =
      32'((PWRT_TIME_NS * CLK_MHZ + 999) / 1000);
   typedef enum logic [1:0] {
      NVAC_KEY_IDLE, NVAC_KEY_HALF, NVAC_KEY_ARMED
   } nvac_key_type;
endpackage : nvac_pkg

//--- design/nvac_timer.sv
// down-counter giving a one-cycle done pulse after COUNT cycles
`timescale 1ns/100ps
module nvac_timer #(
   parameter int unsigned COUNT = 16
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic start,
   input  wire logic abort,
   output logic      running,
   output logic      done
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] cnt_ff, nxt_cnt;
   logic         done_ff, nxt_done;

   // abort wins over start so a reset never leaves a cycle half running
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_done = 1'b0;
      if (abort) begin
         nxt_cnt = '0;
      end else if (start) begin
         nxt_cnt = W'(COUNT);
      end else if (cnt_ff != '0) begin
         nxt_cnt  = cnt_ff - 1'b1;
         nxt_done = (cnt_ff == W'(1));
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign running = (cnt_ff != '0);
   assign done    = done_ff;
endmodule : nvac_timer

//--- design/nvac_top.sv
// nonvolatile access controller with an AXI4-Lite register slave
`timescale 1ns/100ps
module nvac_top #(
   parameter int unsigned WRITE_CYC = nvac_pkg::WRITE_CYCLES,
   parameter int unsigned PWRT_CYC  = nvac_pkg::PWRT_CYCLES,
   parameter int          TP_W      = nvac_pkg::TP_W_DEF
) (
   input  wire logic                      clk,
   input  wire logic                      resetn,
   input  wire logic                      warm_reset,
   input  wire logic                      code_protect,
   input  wire logic                      ext_access_req,
   input  wire logic [7:0]                mem_rdata,
   input  wire logic [nvac_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [nvac_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic                           irq,
   output logic [TP_W-1:0]                mem_addr,
   output logic [7:0]                     mem_wdata,
   output logic                           mem_rd,
   output logic                           mem_busy,
   output logic                           mem_erase,
   output logic                           mem_prog_sel,
   output logic                           mem_cfg_sel,
   output logic                           ext_access_grant
);
   import nvac_pkg::*;

   // bus side state
   logic              aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
   logic              awready_ff, nxt_awready, wready_ff, nxt_wready;
   logic              bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
   logic              rvalid_ff, nxt_rvalid;
   logic [AXI_AW-1:0] awaddr_ff, nxt_awaddr;
   logic [7:0]        wdata_ff, nxt_wdata;
   logic              wstrb_ff, nxt_wstrb;
   logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0]       rdata_ff, nxt_rdata;
   // control state
   logic              pgd_ff, nxt_pgd, config_space_select_ff, nxt_config_space_select, free_ff, nxt_free;
   logic              werr_ff, nxt_werr, write_enable_bit_ff, nxt_write_enable_bit;
   logic              wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [7:0]        addr_ff, nxt_addr, data_ff, nxt_data;
   logic [TP_W-1:0]   tblp_ff, nxt_tblp, maddr_ff, nxt_maddr;
   logic [7:0]        mwdata_ff, nxt_mwdata;
   logic              mrd_ff, nxt_mrd, mbusy_ff, nxt_mbusy;
   logic              merase_ff, nxt_merase, mpgd_ff, nxt_mpgd;
   logic              mcfg_ff, nxt_mcfg, grant_ff, nxt_grant;
   logic              pwrt_go_ff, pwrt_done_ff, nxt_pwrt_done;
   // interrupt state
   logic [IRQ_W-1:0]  irq_st_ff, nxt_irq_st, irq_en_ff, nxt_irq_en;
   logic [IRQ_W-1:0]  irq_ev;
   logic              irq_ff, nxt_irq;
   // helpers
   logic              wr_go, w_en, ctrl_we, key_we, other_we;
   logic              wr_start, rd_start, armed;
   logic              wr_done, pwrt_done, wr_run;

   function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
      is_mapped = (a == OFS_CTRL) || (a == OFS_KEY) || (a == OFS_ADDR) ||
                  (a == OFS_DATA) || (a == OFS_TBLP) || (a == OFS_IRQ_ST) ||
                  (a == OFS_IRQ_CLR) || (a == OFS_IRQ_EN) || (a == OFS_STAT);
   endfunction : is_mapped

   // write-only registers read as zero
   function automatic logic [31:0] reg_read(input logic [AXI_AW-1:0] a);
      reg_read = '0;
      unique case (a)
         OFS_CTRL:   reg_read[7:0] = {pgd_ff, config_space_select_ff, 1'b0, free_ff,
                                      werr_ff, write_enable_bit_ff, wr_ff, rd_ff};
         OFS_ADDR:   reg_read[7:0] = addr_ff;
         OFS_DATA:   reg_read[7:0] = data_ff;
         OFS_TBLP:   reg_read[TP_W-1:0] = tblp_ff;
         OFS_IRQ_ST: reg_read[IRQ_W-1:0] = irq_st_ff;
         OFS_IRQ_EN: reg_read[IRQ_W-1:0] = irq_en_ff;
         OFS_STAT:   reg_read[3:0] = {code_protect, armed, pwrt_done_ff,
                                      wr_ff};
         default:    reg_read = '0;
      endcase
   endfunction : reg_read

   // decode of the write that lands this cycle; only lane 0 holds data
   assign wr_go    = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign w_en     = wr_go & wstrb_ff;
   assign ctrl_we  = w_en && (awaddr_ff == OFS_CTRL);
   assign key_we   = w_en && (awaddr_ff == OFS_KEY);
   assign other_we = w_en && (awaddr_ff != OFS_KEY);
   // internal start paths ignore code_protect on purpose
   assign wr_start = ctrl_we && wdata_ff[B_WR] && write_enable_bit_ff && armed &&
                     pwrt_done_ff && !wr_ff && !warm_reset;
   assign rd_start = ctrl_we && wdata_ff[B_RD] && !wr_ff && !warm_reset &&
                     !wdata_ff[B_PGD] && !wdata_ff[B_CONFIG_SPACE_SELECT];

   nvac_unlock u_unlock (
      .clk      (clk),
      .resetn   (resetn),
      .key_we   (key_we),
      .key_data (wdata_ff),
      .other_we (other_we),
      .flush    (warm_reset),
      .armed    (armed)
   );

   nvac_timer #(.COUNT(WRITE_CYC)) u_wr_tmr (
      .clk     (clk),
      .resetn  (resetn),
      .start   (wr_start),
      .abort   (warm_reset),
      .running (wr_run),
      .done    (wr_done)
   );

   nvac_timer #(.COUNT(PWRT_CYC)) u_pwrt_tmr (
      .clk     (clk),
      .resetn  (resetn),
      .start   (pwrt_go_ff),
      .abort   (1'b0),
      .running (),
      .done    (pwrt_done)
   );

   // bus slave: address and data taken in either order, answer after both
   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_w_held  = w_held_ff;
      nxt_awaddr  = awaddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rresp   = rresp_ff;
      nxt_rdata   = rdata_ff;
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_held = 1'b1;
         nxt_awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_held = 1'b1;
         nxt_wdata  = s_axi_wdata[7:0];
         nxt_wstrb  = s_axi_wstrb[0];
      end
      if (wr_go) begin
         nxt_aw_held = 1'b0;
         nxt_w_held  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (s_axi_arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rdata  = reg_read(s_axi_araddr);
         nxt_rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      nxt_awready = !nxt_aw_held && !nxt_bvalid;
      nxt_wready  = !nxt_w_held && !nxt_bvalid;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= RESP_OKAY;
         rdata_ff   <= '0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         arready_ff <= 1'b0;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff  <= nxt_w_held;
         awaddr_ff  <= nxt_awaddr;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         rvalid_ff  <= nxt_rvalid;
         rresp_ff   <= nxt_rresp;
         rdata_ff   <= nxt_rdata;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         arready_ff <= nxt_arready;
      end
   end

   // control register and memory port; hardware updates follow software
   always_comb begin
      nxt_pgd    = pgd_ff;
      nxt_config_space_select   = config_space_select_ff;
      nxt_free   = free_ff;
      nxt_werr   = werr_ff;
      nxt_write_enable_bit   = write_enable_bit_ff;
      nxt_wr     = wr_ff;
      nxt_rd     = rd_ff;
      nxt_addr   = addr_ff;
      nxt_data   = data_ff;
      nxt_tblp   = tblp_ff;
      nxt_mrd    = 1'b0;
      nxt_mbusy  = mbusy_ff;
      nxt_merase = merase_ff;
      nxt_mpgd   = mpgd_ff;
      nxt_mcfg   = mcfg_ff;
      nxt_grant  = ext_access_req && !code_protect;
      nxt_pwrt_done = pwrt_done_ff || pwrt_done;
      irq_ev     = '0;
      if (ctrl_we) begin
         nxt_pgd  = wdata_ff[B_PGD];
         nxt_config_space_select = wdata_ff[B_CONFIG_SPACE_SELECT];
         nxt_free = wdata_ff[B_FREE];
         nxt_werr = wdata_ff[B_WERR];
         nxt_write_enable_bit = wdata_ff[B_WRITE_ENABLE_BIT];
      end
      if (w_en && awaddr_ff == OFS_ADDR) nxt_addr = wdata_ff;
      if (w_en && awaddr_ff == OFS_DATA) nxt_data = wdata_ff;
      if (w_en && awaddr_ff == OFS_TBLP) nxt_tblp = TP_W'(wdata_ff);
      // port follows the selection written this cycle, frozen while busy
      nxt_mwdata = wr_ff ? mwdata_ff : nxt_data;
      nxt_maddr  = wr_ff ? maddr_ff : ((nxt_pgd || nxt_config_space_select) ? nxt_tblp :
                                       TP_W'(nxt_addr));
      // start bits: a zero written to them simply falls through
      if (wr_start) begin
         nxt_wr     = 1'b1;
         nxt_mbusy  = 1'b1;
         nxt_mpgd   = nxt_pgd;
         nxt_mcfg   = nxt_config_space_select;
         nxt_merase = nxt_free && nxt_pgd && !nxt_config_space_select;
      end
      if (rd_start) begin
         nxt_rd  = 1'b1;
         nxt_mrd = 1'b1;
      end
      if (rd_ff) begin
         nxt_data = mem_rdata;
         nxt_rd   = 1'b0;
         irq_ev[IRQ_RDONE] = 1'b1;
      end
      if (wr_done) begin
         nxt_wr    = 1'b0;
         nxt_mbusy = 1'b0;
         nxt_merase = 1'b0;
         if (merase_ff) nxt_free = 1'b0;
         irq_ev[IRQ_WDONE] = 1'b1;
      end
      // warm reset keeps both selection bits, flags a cut-short cycle
      if (warm_reset) begin
         nxt_wr    = 1'b0;
         nxt_rd    = 1'b0;
         nxt_write_enable_bit  = 1'b0;
         nxt_free  = 1'b0;
         nxt_mbusy = 1'b0;
         nxt_merase = 1'b0;
         if (wr_ff) begin
            nxt_werr = 1'b1;
            irq_ev[IRQ_WERR] = 1'b1;
         end
      end
   end

   // write enable and error start cleared at power-up
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pgd_ff       <= 1'b0;
         config_space_select_ff      <= 1'b0;
         free_ff      <= 1'b0;
         werr_ff      <= 1'b0;
         write_enable_bit_ff      <= 1'b0;
         wr_ff        <= 1'b0;
         rd_ff        <= 1'b0;
         addr_ff      <= '0;
         data_ff      <= '0;
         tblp_ff      <= '0;
         mwdata_ff    <= '0;
         maddr_ff     <= '0;
         mrd_ff       <= 1'b0;
         mbusy_ff     <= 1'b0;
         merase_ff    <= 1'b0;
         mpgd_ff      <= 1'b0;
         mcfg_ff      <= 1'b0;
         grant_ff     <= 1'b0;
         pwrt_go_ff   <= 1'b1;
         pwrt_done_ff <= 1'b0;
      end else begin
         pgd_ff       <= nxt_pgd;
         config_space_select_ff      <= nxt_config_space_select;
         free_ff      <= nxt_free;
         werr_ff      <= nxt_werr;
         write_enable_bit_ff      <= nxt_write_enable_bit;
         wr_ff        <= nxt_wr;
         rd_ff        <= nxt_rd;
         addr_ff      <= nxt_addr;
         data_ff      <= nxt_data;
         tblp_ff      <= nxt_tblp;
         mwdata_ff    <= nxt_mwdata;
         maddr_ff     <= nxt_maddr;
         mrd_ff       <= nxt_mrd;
         mbusy_ff     <= nxt_mbusy;
         merase_ff    <= nxt_merase;
         mpgd_ff      <= nxt_mpgd;
         mcfg_ff      <= nxt_mcfg;
         grant_ff     <= nxt_grant;
         pwrt_go_ff   <= 1'b0;
         pwrt_done_ff <= nxt_pwrt_done;
      end
   end

   // sticky status: a new event wins over a clear in the same cycle
   always_comb begin
      nxt_irq_st = irq_st_ff;
      nxt_irq_en = irq_en_ff;
      if (w_en && awaddr_ff == OFS_IRQ_CLR)
         nxt_irq_st = irq_st_ff & ~wdata_ff[IRQ_W-1:0];
      if (w_en && awaddr_ff == OFS_IRQ_EN) nxt_irq_en = wdata_ff[IRQ_W-1:0];
      nxt_irq_st = nxt_irq_st | irq_ev;
      nxt_irq    = |(nxt_irq_st & nxt_irq_en);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_st_ff <= '0;
         irq_en_ff <= '0;
         irq_ff    <= 1'b0;
      end else begin
         irq_st_ff <= nxt_irq_st;
         irq_en_ff <= nxt_irq_en;
         irq_ff    <= nxt_irq;
      end
   end

   assign s_axi_awready    = awready_ff;
   assign s_axi_wready     = wready_ff;
   assign s_axi_bvalid     = bvalid_ff;
   assign s_axi_bresp      = bresp_ff;
   assign s_axi_arready    = arready_ff;
   assign s_axi_rvalid     = rvalid_ff;
   assign s_axi_rresp      = rresp_ff;
   assign s_axi_rdata      = rdata_ff;
   assign irq              = irq_ff;
   assign mem_addr         = maddr_ff;
   assign mem_wdata        = mwdata_ff;
   assign mem_rd           = mrd_ff;
   assign mem_busy         = mbusy_ff;
   assign mem_erase        = merase_ff;
   assign mem_prog_sel     = mpgd_ff;
   assign mem_cfg_sel      = mcfg_ff;
   assign ext_access_grant = grant_ff;

   // checks of the access rules
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_wr_gate;
      $rose(wr_ff) |-> $past(write_enable_bit_ff && armed && ctrl_we);
   endproperty
   a_wr_gate: assert property (p_wr_gate) else $error("bad write start");
   property p_wr_pwrt;
      !pwrt_done_ff |-> !wr_ff && !mbusy_ff;
   endproperty
   a_wr_pwrt: assert property (p_wr_pwrt) else $error("write in pwrt");
   property p_wr_hold;
      wr_ff && !wr_done && !warm_reset |=> wr_ff;
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("wr dropped");
   property p_wr_end;
      $fell(wr_ff) |-> $past(wr_done || warm_reset);
   endproperty
   a_wr_end: assert property (p_wr_end) else $error("wr cleared early");
   property p_rd_one;
      rd_ff |=> !rd_ff && data_ff == $past(mem_rdata);
   endproperty
   a_rd_one: assert property (p_rd_one) else $error("read not 1 cycle");
   property p_rd_sel;
      $rose(rd_ff) |-> !pgd_ff && !config_space_select_ff && mrd_ff;
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("read with sel set");
   property p_free_clr;
      wr_done && merase_ff |=> !free_ff && !wr_ff;
   endproperty
   a_free_clr: assert property (p_free_clr) else $error("erase en kept");
   property p_abort;
      warm_reset && wr_ff |=> werr_ff && !wr_ff && pgd_ff == $past(pgd_ff)
         && config_space_select_ff == $past(config_space_select_ff);
   endproperty
   a_abort: assert property (p_abort) else $error("abort not flagged");
   property p_cp;
      code_protect |=> !ext_access_grant;
   endproperty
   a_cp: assert property (p_cp) else $error("grant under protect");

   c_write_done: cover property (wr_ff ##1 wr_done);
   c_read:       cover property ($rose(rd_ff));
   c_refused:    cover property (ctrl_we && wdata_ff[B_WR] && !armed);
   c_abort:      cover property (warm_reset && wr_ff);
endmodule : nvac_top

//--- design/nvac_unlock.sv
// two-key unlock detector, armed for the very next bus write only
`timescale 1ns/100ps
module nvac_unlock (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       key_we,
   input  wire logic [7:0] key_data,
   input  wire logic       other_we,
   input  wire logic       flush,
   output logic            armed
);
   import nvac_pkg::*;
   nvac_key_type st_ff, nxt_st;

   // any other write between the keys and the start bit disarms
   always_comb begin
      nxt_st = st_ff;
      if (flush) begin
         nxt_st = NVAC_KEY_IDLE;
      end else if (key_we) begin
         if (key_data == KEY_FIRST) begin
            nxt_st = NVAC_KEY_HALF;
         end else if (key_data == KEY_SECOND && st_ff == NVAC_KEY_HALF) begin
            nxt_st = NVAC_KEY_ARMED;
         end else begin
            nxt_st = NVAC_KEY_IDLE;
         end
      end else if (other_we) begin
         nxt_st = NVAC_KEY_IDLE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= NVAC_KEY_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign armed = (st_ff == NVAC_KEY_ARMED);
endmodule : nvac_unlock

//--- tb/tb_top.sv
// self-checking bench of the nonvolatile access controller
`timescale 1ns/100ps
module tb_top;
   import nvac_pkg::*;
   localparam int unsigned WC = 20;
   localparam int unsigned PW = 60;
   logic        clk, resetn, warm_reset, code_protect, ext_access_req;
   logic [7:0]  mem_rdata, mem_wdata, s_axi_awaddr, s_axi_araddr;
   logic [TP_W_DEF-1:0] mem_addr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_rresp, s_axi_bresp, resp, bresp_q;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, irq, mem_busy, mem_erase;
   logic        mem_prog_sel, mem_cfg_sel, mem_rd, ext_access_grant;
   int          error_cnt, n_checks, n;
   int          n_rd = 0;

   nvac_top #(.WRITE_CYC(WC), .PWRT_CYC(PW)) dut_u (
      .clk, .resetn, .warm_reset, .code_protect, .ext_access_req,
      .mem_rdata, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq, .mem_addr, .mem_wdata,
      .mem_rd, .mem_busy, .mem_erase, .mem_prog_sel, .mem_cfg_sel,
      .ext_access_grant);

   // free-running 125 MHz clock
   always #4 clk = ~clk;

   // the read strobe stands one cycle only, so count it at every edge
   always @(posedge clk) begin
      if (mem_rd === 1'b1) n_rd <= n_rd + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // bready is held high throughout, so a write ends at the bvalid edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge clk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      bresp_q = s_axi_bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      resp = s_axi_rresp;
   endtask : rd

   task automatic unlock;
      wr(OFS_KEY, KEY_FIRST);
      wr(OFS_KEY, KEY_SECOND);
   endtask : unlock

   // counts cycles of mem_busy, capped so a stuck cycle still ends
   task automatic busy_len;
      n = 0;
      @(negedge clk);
      while (mem_busy && n < 200) begin
         n++;
         @(negedge clk);
      end
   endtask : busy_len

   task automatic results;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   // watchdog, well above the length of the sequence
   initial begin
      repeat (4000) @(posedge clk);
      error_cnt++;
      results();
   end

   initial begin
      {clk, resetn, warm_reset, code_protect, ext_access_req} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_bready, s_axi_rready} = 2'b11;
      s_axi_wstrb = 4'h1;
      mem_rdata = 8'h5a;
      error_cnt = 0;
      n_checks = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(OFS_CTRL);
      chk(d[B_WRITE_ENABLE_BIT], 1'b0);
      wr(OFS_IRQ_EN, 8'h01);
      chk(bresp_q, RESP_OKAY);
      wr(OFS_CTRL, 8'h04);
      unlock();
      wr(OFS_CTRL, 8'h06);
      rd(OFS_STAT);
      chk(d[ST_PWRT], 1'b0);
      chk(mem_busy, 1'b0);
      repeat (PW) @(posedge clk);
      wr(OFS_CTRL, 8'h06);
      busy_len();
      chk(n, 0);
      unlock();
      wr(OFS_CTRL, 8'h06);
      busy_len();
      chk(n, WC);
      rd(OFS_CTRL);
      chk(d[7:0], 8'h04);
      chk(irq, 1'b1);
      wr(OFS_IRQ_CLR, 8'h07);
      rd(OFS_IRQ_ST);
      chk(irq, 1'b0);
      // row erase, with a zero write to write-start in mid-cycle
      wr(OFS_TBLP, 8'h25);
      wr(OFS_DATA, 8'hc3);
      unlock();
      wr(OFS_CTRL, 8'h96);
      @(negedge clk);
      chk({mem_erase, mem_prog_sel, mem_cfg_sel}, 3'b110);
      chk(mem_addr, 32'h25);
      chk(mem_wdata, 8'hc3);
      wr(OFS_CTRL, 8'h94);
      rd(OFS_CTRL);
      chk(d[B_WR], 1'b1);
      busy_len();
      rd(OFS_CTRL);
      chk(d[7:0], 8'h84);
      chk(mem_erase, 1'b0);
      // erase-done status cleared, only the abort event may raise irq now
      wr(OFS_IRQ_CLR, 8'h07);
      wr(OFS_IRQ_EN, 8'h02);
      // a warm reset cuts a write short
      unlock();
      wr(OFS_CTRL, 8'h86);
      @(posedge clk);
      warm_reset <= 1'b1;
      @(posedge clk);
      warm_reset <= 1'b0;
      rd(OFS_CTRL);
      chk(d[7:0], 8'h88);
      chk({irq, mem_busy}, 2'b10);
      wr(OFS_IRQ_CLR, 8'h07);
      wr(OFS_CTRL, 8'h81);
      rd(OFS_IRQ_ST);
      chk(d[IRQ_RDONE], 1'b0);
      wr(OFS_ADDR, 8'h3c);
      wr(OFS_CTRL, 8'h01);
      rd(OFS_CTRL);
      chk(d[B_RD], 1'b0);
      chk(mem_addr, 32'h3c);
      chk(n_rd, 1);
      rd(OFS_IRQ_ST);
      chk(d[IRQ_RDONE], 1'b1);
      @(posedge clk);
      code_protect <= 1'b1;
      ext_access_req <= 1'b1;
      rd(OFS_DATA);
      chk(d[7:0], 8'h5a);
      chk(ext_access_grant, 1'b0);
      @(posedge clk);
      code_protect <= 1'b0;
      repeat (2) @(negedge clk);
      chk(ext_access_grant, 1'b1);
      rd(8'h40);
      chk(resp, RESP_SLVERR);
      wr(8'h40, 8'h00);
      chk(bresp_q, RESP_SLVERR);
      results();
   end
endmodule : tb_top
